// >>> rtl/cogc_clk_gate.sv
`timescale 1ns/1ns
module cogc_clk_gate #(
	parameter logic STOP_LEVEL = 1'b0
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_src,
	input wire logic i_run,
	output logic o_clk,
	output logic o_clk_n,
	output logic o_running
);

	logic running_r;
	logic running_nxt;
	logic clk_r;
	logic clk_n_r;

	// run state may only change while the source sits at the stop level
	always_comb begin
		running_nxt = running_r;
		if (i_src == STOP_LEVEL) begin
			running_nxt = i_run;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			running_r <= 1'b0;
		end else begin
			running_r <= running_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			clk_r <= STOP_LEVEL;
			clk_n_r <= ~STOP_LEVEL;
		end else begin
			clk_r <= running_nxt ? i_src : STOP_LEVEL;
			clk_n_r <= running_nxt ? ~i_src : ~STOP_LEVEL;
		end
	end

	assign o_clk = clk_r;
	assign o_clk_n = clk_n_r;
	assign o_running = running_r;

endmodule

// >>> rtl/cogc_pkg.sv
package cogc_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] ADDR_CFG0 = 8'h00;
	localparam logic [7:0] ADDR_CFG3 = 8'h03;
	localparam logic [7:0] ADDR_STOP_CTL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h09;

	// configuration byte 0 fields
	localparam int CFG0_SPREAD_BIT = 7;
	localparam int CFG0_PD_TRISTATE_BIT = 6;
	localparam int CFG0_VCH_48M_BIT = 5;
	localparam int CFG0_HOST_STOP_BIT = 4;
	localparam int CFG0_BUS_STOP_BIT = 3;
	localparam int CFG0_FSEL_LSB = 0;

	// configuration byte 3 fields
	localparam int CFG3_FREE_RUN_LSB = 3;

	// own control and status fields
	localparam int STOP_CTL_BUS_RUN_BIT = 0;
	localparam int STATUS_PD_BIT = 0;
	localparam int STATUS_MULT_BIT = 1;
	localparam int STATUS_TRI_LSB = 2;
	localparam int STATUS_EXT_SRC_BIT = 4;

	// values after reset
	localparam logic [7:0] CFG0_RESET = 8'h00;
	localparam logic [7:0] CFG3_RESET = 8'h00;
	localparam logic STOP_CTL_BUS_RUN_RESET = 1'b1;

	// output counts
	localparam int BUS_CLK_COUNT = 7;
	localparam int FREE_CLK_COUNT = 3;
	localparam int HOST_PAIR_COUNT = 3;
	localparam int EXT_BUF_COUNT = 3;

	// synchroniser depth for pins
	localparam int SYNC_STAGES = 2;

	// three-level select input as reported by its comparators
	typedef enum logic [1:0] {
		TRI_LOW = 2'b00,
		TRI_MID = 2'b01,
		TRI_HIGH = 2'b11
	} cogc_tri_e;

	typedef enum logic [0:0] {
		PWR_RUN = 1'b0,
		PWR_DOWN = 1'b1
	} cogc_pwr_e;

	// selections latched under the qualifying input
	typedef struct packed {
		cogc_tri_e tri_sel;
		logic [1:0] fsel_low;
		logic mult;
	} cogc_strap_s;

	// raw pin group before synchronisation
	typedef struct packed {
		logic powerdown_n;
		logic bus_stop_n;
		logic host_stop_n;
		logic latch_qualify_n;
		logic [1:0] fsel_low;
		logic [1:0] tri_code;
		logic mult;
		logic ext_clk;
		logic osc;
		logic sdl;
	} cogc_pins_s;

	// synchroniser contents in reset: pulled-up pins idle high, so no false powerdown
	localparam cogc_pins_s PINS_RESET = '{
		powerdown_n: 1'b1,
		bus_stop_n: 1'b1,
		host_stop_n: 1'b1,
		latch_qualify_n: 1'b0,
		fsel_low: 2'h0,
		tri_code: 2'h0,
		mult: 1'b1,
		ext_clk: 1'b0,
		osc: 1'b0,
		sdl: 1'b1
	};

endpackage

// >>> rtl/cogc_top.sv
`timescale 1ns/1ns
module cogc_top #(
	parameter int BUS_CLKS = cogc_pkg::BUS_CLK_COUNT,
	parameter int FREE_CLKS = cogc_pkg::FREE_CLK_COUNT,
	parameter int HOST_PAIRS = cogc_pkg::HOST_PAIR_COUNT,
	parameter int EXT_BUFS = cogc_pkg::EXT_BUF_COUNT
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wr_data,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rd_data,
	// control pins
	input wire logic i_powerdown_n,
	input wire logic i_bus_clock_stop_n,
	input wire logic i_host_clock_stop_n,
	input wire logic i_latch_qualify_n,
	input wire logic [1:0] i_freq_sel,
	input wire logic [1:0] i_tri_level_sel,
	input wire logic i_current_mult_sel,
	input wire logic i_osc_input,
	// synthesized clock phases
	input wire logic i_host_src,
	input wire logic i_int66_src,
	input wire logic i_int48_src,
	// shared 66 pin
	input wire logic i_ext_bus_clk_io,
	output logic o_ext_bus_clk_io,
	output logic o_ext_bus_clk_oe,
	// serial data line
	input wire logic i_serial_data_line,
	input wire logic i_serial_drive_low,
	output logic o_serial_data_line,
	output logic o_serial_data_oe,
	output logic o_serial_data_in,
	// clock outputs
	output logic [HOST_PAIRS-1:0] o_host_clk_true,
	output logic [HOST_PAIRS-1:0] o_host_clk_comp,
	output logic o_host_oe,
	output logic o_host_current_mult,
	output logic [BUS_CLKS-1:0] o_bus_clock_out,
	output logic [FREE_CLKS-1:0] o_free_bus_clock_out,
	output logic [EXT_BUFS-1:0] o_ext_buffered_outs,
	output logic o_selectable_video_out,
	output logic o_fixed_agp_out,
	output logic o_usb_fixed_out,
	output logic o_display_fixed_out,
	output logic o_ref_out,
	// latched selections
	output cogc_pkg::cogc_strap_s o_strap
);

	cogc_pkg::cogc_pins_s pins_raw;
	cogc_pkg::cogc_pins_s pins_meta_r;
	cogc_pkg::cogc_pins_s pins_s_r;
	cogc_pkg::cogc_strap_s strap_r;
	cogc_pkg::cogc_strap_s strap_nxt;
	cogc_pkg::cogc_pwr_e pwr_r;
	cogc_pkg::cogc_pwr_e pwr_nxt;
	cogc_pkg::cogc_tri_e tri_now;

	logic [7:0] cfg0_r;
	logic [7:0] cfg3_r;
	logic bus_run_bit_r;
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic [7:0] status_word;
	logic [7:0] cfg0_view;

	logic run_all;
	logic bus_stop_int_n;
	logic ext_src_sel;
	logic src66;
	logic src66_prev_r;
	logic div2_r;
	logic [FREE_CLKS-1:0] free_mode;
	logic [BUS_CLKS-1:0] bus_clk;
	logic [FREE_CLKS-1:0] free_clk;
	logic [HOST_PAIRS-1:0] host_true;
	logic [HOST_PAIRS-1:0] host_comp;
	logic [EXT_BUFS-1:0] ext_buf;
	logic [5:0] misc_src;
	logic [5:0] misc_run;
	logic [5:0] misc_clk;

	assign pins_raw = '{
		powerdown_n: i_powerdown_n,
		bus_stop_n: i_bus_clock_stop_n,
		host_stop_n: i_host_clock_stop_n,
		latch_qualify_n: i_latch_qualify_n,
		fsel_low: i_freq_sel,
		tri_code: i_tri_level_sel,
		mult: i_current_mult_sel,
		ext_clk: i_ext_bus_clk_io,
		osc: i_osc_input,
		sdl: i_serial_data_line
	};

	// two-stage synchroniser for every pin; pull-ups read as high at reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pins_meta_r <= cogc_pkg::PINS_RESET;
			pins_s_r <= cogc_pkg::PINS_RESET;
		end else begin
			pins_meta_r <= pins_raw;
			pins_s_r <= pins_meta_r;
		end
	end

	// three-level select decode, unknown codes read as mid level
	always_comb begin
		case (pins_s_r.tri_code)
			2'b00: tri_now = cogc_pkg::TRI_LOW;
			2'b11: tri_now = cogc_pkg::TRI_HIGH;
			default: tri_now = cogc_pkg::TRI_MID;
		endcase
	end

	// selections follow the pins until qualify goes low, then hold
	always_comb begin
		strap_nxt = strap_r;
		if (pins_s_r.latch_qualify_n) begin
			strap_nxt.tri_sel = tri_now;
			strap_nxt.fsel_low = pins_s_r.fsel_low;
			strap_nxt.mult = pins_s_r.mult;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			strap_r <= '{tri_sel: cogc_pkg::TRI_LOW, fsel_low: 2'h0, mult: 1'b0};
		end else begin
			strap_r <= strap_nxt;
		end
	end

	// power mode
	always_comb begin
		case (pwr_r)
			cogc_pkg::PWR_RUN: pwr_nxt = pins_s_r.powerdown_n ? cogc_pkg::PWR_RUN :
				cogc_pkg::PWR_DOWN;
			cogc_pkg::PWR_DOWN: pwr_nxt = pins_s_r.powerdown_n ? cogc_pkg::PWR_RUN :
				cogc_pkg::PWR_DOWN;
			default: pwr_nxt = cogc_pkg::PWR_DOWN;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pwr_r <= cogc_pkg::PWR_RUN;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	assign run_all = (pwr_r == cogc_pkg::PWR_RUN);

	// configuration registers, writable in powerdown as well
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cfg0_r <= cogc_pkg::CFG0_RESET;
			cfg3_r <= cogc_pkg::CFG3_RESET;
			bus_run_bit_r <= cogc_pkg::STOP_CTL_BUS_RUN_RESET;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				cogc_pkg::ADDR_CFG0: begin
					cfg0_r[7:5] <= i_reg_wr_data[7:5];
				end
				cogc_pkg::ADDR_CFG3: begin
					cfg3_r <= i_reg_wr_data;
				end
				cogc_pkg::ADDR_STOP_CTL: begin
					bus_run_bit_r <= i_reg_wr_data[cogc_pkg::STOP_CTL_BUS_RUN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// internal bus stop: either the register bit or the pin stops
	assign bus_stop_int_n = bus_run_bit_r & pins_s_r.bus_stop_n;

	always_comb begin
		cfg0_view = cfg0_r;
		cfg0_view[cogc_pkg::CFG0_HOST_STOP_BIT] = pins_s_r.host_stop_n;
		cfg0_view[cogc_pkg::CFG0_BUS_STOP_BIT] = bus_stop_int_n;
		cfg0_view[cogc_pkg::CFG0_FSEL_LSB +: 2] = strap_r.fsel_low;
		cfg0_view[cogc_pkg::CFG0_FSEL_LSB + 2] = (strap_r.tri_sel == cogc_pkg::TRI_HIGH);
	end

	always_comb begin
		status_word = 8'h00;
		status_word[cogc_pkg::STATUS_PD_BIT] = ~run_all;
		status_word[cogc_pkg::STATUS_MULT_BIT] = strap_r.mult;
		status_word[cogc_pkg::STATUS_TRI_LSB +: 2] = strap_r.tri_sel;
		status_word[cogc_pkg::STATUS_EXT_SRC_BIT] = ext_src_sel;
	end

	// read data one cycle after the strobe, zero for unmapped addresses
	always_comb begin
		rd_data_nxt = 8'h00;
		if (i_reg_rd) begin
			case (i_reg_addr)
				cogc_pkg::ADDR_CFG0: rd_data_nxt = cfg0_view;
				cogc_pkg::ADDR_CFG3: rd_data_nxt = cfg3_r;
				cogc_pkg::ADDR_STOP_CTL: rd_data_nxt = {7'h00, bus_run_bit_r};
				cogc_pkg::ADDR_STATUS: rd_data_nxt = status_word;
				default: rd_data_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rd_data_r <= 8'h00;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	assign o_reg_rd_data = rd_data_r;

	// 66 source: external pin only with tri-level select high
	assign ext_src_sel = (strap_r.tri_sel == cogc_pkg::TRI_HIGH);
	assign src66 = ext_src_sel ? pins_s_r.ext_clk : i_int66_src;

	// halve the active 66 source; in powerdown finish the high half, then freeze low
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			src66_prev_r <= 1'b0;
			div2_r <= 1'b0;
		end else if (run_all || div2_r) begin
			src66_prev_r <= src66;
			if (src66 && !src66_prev_r) begin
				div2_r <= ~div2_r;
			end
		end
	end

	assign free_mode = cfg3_r[cogc_pkg::CFG3_FREE_RUN_LSB +: FREE_CLKS];

	// misc outputs: 0 shared pin, 1 selectable, 2 fixed 66, 3 usb, 4 display, 5 reference
	assign misc_src[0] = i_int66_src;
	assign misc_src[1] = cfg0_r[cogc_pkg::CFG0_VCH_48M_BIT] ?
		i_int48_src : i_int66_src;
	assign misc_src[2] = i_int66_src;
	assign misc_src[3] = i_int48_src;
	assign misc_src[4] = i_int48_src;
	assign misc_src[5] = pins_s_r.osc;
	// reference: stop pins never reach it, only powerdown
	assign misc_run = {{5{run_all}}, run_all & ~ext_src_sel};

	genvar g;
	generate
		for (g = 0; g < BUS_CLKS; g++) begin : g_bus
			cogc_clk_gate #(.STOP_LEVEL(1'b0)) u_gate (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_src(div2_r),
				.i_run(run_all & bus_stop_int_n),
				.o_clk(bus_clk[g]),
				.o_clk_n(),
				.o_running()
			);
		end
		for (g = 0; g < FREE_CLKS; g++) begin : g_free
			cogc_clk_gate #(.STOP_LEVEL(1'b0)) u_gate (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_src(div2_r),
				.i_run(run_all & (free_mode[g] | bus_stop_int_n)),
				.o_clk(free_clk[g]),
				.o_clk_n(),
				.o_running()
			);
		end
		for (g = 0; g < HOST_PAIRS; g++) begin : g_host
			cogc_clk_gate #(.STOP_LEVEL(1'b1)) u_gate (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_src(i_host_src),
				.i_run(run_all & pins_s_r.host_stop_n),
				.o_clk(host_true[g]),
				.o_clk_n(host_comp[g]),
				.o_running()
			);
		end
		for (g = 0; g < EXT_BUFS; g++) begin : g_ext
			cogc_clk_gate #(.STOP_LEVEL(1'b0)) u_gate (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_src(src66),
				.i_run(run_all),
				.o_clk(ext_buf[g]),
				.o_clk_n(),
				.o_running()
			);
		end
		for (g = 0; g < 6; g++) begin : g_misc
			cogc_clk_gate #(.STOP_LEVEL(1'b0)) u_gate (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_src(misc_src[g]),
				.i_run(misc_run[g]),
				.o_clk(misc_clk[g]),
				.o_clk_n(),
				.o_running()
			);
		end
	endgenerate

	assign o_host_clk_true = host_true;
	assign o_host_clk_comp = host_comp;
	// powerdown with tristate mode releases the host pairs
	assign o_host_oe = run_all | ~cfg0_r[cogc_pkg::CFG0_PD_TRISTATE_BIT];
	assign o_host_current_mult = strap_r.mult;
	assign o_bus_clock_out = bus_clk;
	assign o_free_bus_clock_out = free_clk;
	assign o_ext_buffered_outs = ext_buf;
	assign o_ext_bus_clk_io = misc_clk[0];
	assign o_ext_bus_clk_oe = ~ext_src_sel;
	assign o_selectable_video_out = misc_clk[1];
	assign o_fixed_agp_out = misc_clk[2];
	assign o_usb_fixed_out = misc_clk[3];
	assign o_display_fixed_out = misc_clk[4];
	assign o_ref_out = misc_clk[5];
	assign o_strap = strap_r;

	// serial data: only ever pulls low, never drives high
	assign o_serial_data_line = 1'b0;
	assign o_serial_data_oe = i_serial_drive_low;
	assign o_serial_data_in = pins_s_r.sdl;

endmodule

// >>> testbench/cogc_partner.sv
`timescale 1ns/1ns
module cogc_partner (
	input wire logic i_clock,
	input wire logic i_ext_oe,
	input wire logic i_ext_drv,
	input wire logic i_sdl_oe,
	output logic o_int66_src,
	output logic o_int48_src,
	output logic o_osc,
	output logic o_ext_pin,
	output logic o_sdl
);
	logic [5:0] ph_r = 6'h00;
	always @(posedge i_clock) ph_r <= ph_r + 6'h01;
	assign o_int66_src = ph_r[0];
	assign o_int48_src = ph_r[1];
	assign o_osc = ph_r[2];
	// external 66 only when the shared pin is released by the block
	assign o_ext_pin = i_ext_oe ? i_ext_drv : ~ph_r[0];
	// pull-up on the open-drain line
	assign o_sdl = i_sdl_oe ? 1'b0 : 1'b1;
endmodule

// >>> testbench/cogc_top_asserts.sv
`timescale 1ns/1ns
module cogc_top_asserts #(
	parameter int BUS_CLKS = 7,
	parameter int FREE_CLKS = 3,
	parameter int HOST_PAIRS = 3
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wr_data,
	input wire logic i_reg_wr,
	input wire logic i_powerdown_n,
	input wire logic i_bus_clock_stop_n,
	input wire logic i_host_clock_stop_n,
	input wire logic i_latch_qualify_n,
	input wire logic [1:0] i_tri_level_sel,
	input wire logic i_osc_input,
	input wire logic i_serial_drive_low,
	input wire logic o_serial_data_line,
	input wire logic o_serial_data_oe,
	input wire logic [HOST_PAIRS-1:0] o_host_clk_true,
	input wire logic [HOST_PAIRS-1:0] o_host_clk_comp,
	input wire logic o_host_oe,
	input wire logic [BUS_CLKS-1:0] o_bus_clock_out,
	input wire logic [FREE_CLKS-1:0] o_free_bus_clock_out,
	input wire logic o_ref_out,
	input wire logic o_usb_fixed_out,
	input wire logic o_ext_bus_clk_oe,
	input wire cogc_pkg::cogc_strap_s o_strap
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic pd_tri_r;
	logic free0_r;
	// shadows of the writable bits the outputs depend on
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			pd_tri_r <= 1'b0;
			free0_r <= 1'b0;
		end else if (i_reg_wr && i_reg_addr == cogc_pkg::ADDR_CFG0) begin
			pd_tri_r <= i_reg_wr_data[cogc_pkg::CFG0_PD_TRISTATE_BIT];
		end else if (i_reg_wr && i_reg_addr == cogc_pkg::ADDR_CFG3) begin
			free0_r <= i_reg_wr_data[cogc_pkg::CFG3_FREE_RUN_LSB];
		end
	end
	a_serial_open_drain: assert property (
		o_serial_data_oe == i_serial_drive_low && !o_serial_data_line)
		else $error("serial line drive wrong");
	a_bus_stop_low: assert property (!i_bus_clock_stop_n [*8] |-> o_bus_clock_out == '0)
		else $error("bus clocks run while stopped");
	a_host_stop_pair: assert property (
		!i_host_clock_stop_n [*8] ##0 o_host_oe |-> o_host_clk_true == '1 && o_host_clk_comp == '0)
		else $error("host pair not parked");
	a_free_keeps_running: assert property (
		(free0_r && i_powerdown_n) [*8] |-> ##[0:4] $changed(o_free_bus_clock_out[0]))
		else $error("free bus clock stuck");
	a_powerdown_quiet: assert property (
		!i_powerdown_n [*8] |-> ##2 (o_bus_clock_out == '0 && o_free_bus_clock_out == '0
		&& !o_ref_out && !o_usb_fixed_out))
		else $error("clock runs in powerdown");
	a_ref_follows_osc: assert property (
		i_powerdown_n [*8] ##0 $changed(i_osc_input) |-> ##[1:5] $changed(o_ref_out))
		else $error("reference output stuck");
	a_strap_held: assert property (!i_latch_qualify_n [*6] |-> $stable(o_strap))
		else $error("selections changed while latched");
	a_host_tristate: assert property (
		!i_powerdown_n [*5] ##0 pd_tri_r |-> !o_host_oe)
		else $error("host outputs driven in powerdown");
	a_host_oe_cause: assert property (!o_host_oe |-> pd_tri_r)
		else $error("host outputs released without cause");
	a_shared_pin_in: assert property (
		(i_powerdown_n && i_latch_qualify_n && i_tri_level_sel == 2'b11) [*8]
		|-> !o_ext_bus_clk_oe)
		else $error("shared pin driven when input");
endmodule
bind cogc_top cogc_top_asserts #(.BUS_CLKS(BUS_CLKS), .FREE_CLKS(FREE_CLKS),
	.HOST_PAIRS(HOST_PAIRS)) cogc_top_asserts_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_reg_addr(i_reg_addr), .i_reg_wr_data(i_reg_wr_data), .i_reg_wr(i_reg_wr),
	.i_powerdown_n(i_powerdown_n), .i_bus_clock_stop_n(i_bus_clock_stop_n),
	.i_host_clock_stop_n(i_host_clock_stop_n), .i_latch_qualify_n(i_latch_qualify_n),
	.i_tri_level_sel(i_tri_level_sel), .i_osc_input(i_osc_input),
	.i_serial_drive_low(i_serial_drive_low), .o_serial_data_line(o_serial_data_line),
	.o_serial_data_oe(o_serial_data_oe), .o_host_clk_true(o_host_clk_true),
	.o_host_clk_comp(o_host_clk_comp), .o_host_oe(o_host_oe),
	.o_bus_clock_out(o_bus_clock_out), .o_free_bus_clock_out(o_free_bus_clock_out),
	.o_ref_out(o_ref_out), .o_usb_fixed_out(o_usb_fixed_out),
	.o_ext_bus_clk_oe(o_ext_bus_clk_oe), .o_strap(o_strap));

// >>> testbench/tb_cogc_top.sv
`timescale 1ns/1ns
module tb_cogc_top;
	logic i_clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic pd_n = 1'b1;
	logic bstop_n = 1'b1;
	logic hstop_n = 1'b1;
	logic qual_n = 1'b1;
	logic [1:0] fsel = 2'b10;
	logic [1:0] tri_sel = 2'b00;
	logic mult = 1'b0;
	logic sdrv = 1'b0;
	logic i66, i48, osc, ext_pin, sdl, ext_out, ext_oe, sdl_oe, sdl_in, h_oe, vch, usb, ref_o;
	logic agp, dot, hmult;
	logic [7:0] rd_data;
	logic [2:0] h_t, h_c, free, ebuf;
	logic [6:0] bus;
	cogc_pkg::cogc_strap_s strap;
	int err_total = 0;
	int comparisons = 0;
	int vc, fc, ep;
	logic [6:0] bus_seen;
	logic [2:0] ht_all, hc_any;
	logic misc;
	logic [2:0] fx;
	initial forever #50 i_clock = ~i_clock;
	cogc_partner cogc_partner_i (.i_clock(i_clock), .i_ext_oe(ext_oe), .i_ext_drv(ext_out),
		.i_sdl_oe(sdl_oe), .o_int66_src(i66), .o_int48_src(i48), .o_osc(osc),
		.o_ext_pin(ext_pin), .o_sdl(sdl));
	cogc_top cogc_top_i (.i_clock(i_clock), .i_rst_n(rst_n), .i_reg_addr(addr),
		.i_reg_wr_data(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rd_data(rd_data),
		.i_powerdown_n(pd_n), .i_bus_clock_stop_n(bstop_n), .i_host_clock_stop_n(hstop_n),
		.i_latch_qualify_n(qual_n), .i_freq_sel(fsel), .i_tri_level_sel(tri_sel),
		.i_current_mult_sel(mult), .i_osc_input(osc), .i_host_src(i66), .i_int66_src(i66),
		.i_int48_src(i48), .i_ext_bus_clk_io(ext_pin), .o_ext_bus_clk_io(ext_out),
		.o_ext_bus_clk_oe(ext_oe), .i_serial_data_line(sdl), .i_serial_drive_low(sdrv),
		.o_serial_data_line(), .o_serial_data_oe(sdl_oe), .o_serial_data_in(sdl_in),
		.o_host_clk_true(h_t), .o_host_clk_comp(h_c), .o_host_oe(h_oe),
		.o_host_current_mult(hmult), .o_bus_clock_out(bus), .o_free_bus_clock_out(free),
		.o_ext_buffered_outs(ebuf), .o_selectable_video_out(vch), .o_fixed_agp_out(agp),
		.o_usb_fixed_out(usb), .o_display_fixed_out(dot), .o_ref_out(ref_o), .o_strap(strap));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clock);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge i_clock);
		rd_s <= 1'b0;
		#1;
		chk(rd_data, exp);
	endtask
	// settle, then record activity of the outputs over a window
	task automatic watch();
		logic v0, f0;
		cyc(8);
		#1;
		{vc, fc, ep, bus_seen, ht_all, hc_any, misc, fx} = {96'h0, 7'h00, 3'h7, 3'h0, 1'b0, 3'h0};
		repeat (16) begin
			v0 = vch;
			f0 = free[0];
			@(posedge i_clock);
			#1;
			vc += int'(vch !== v0);
			fc += int'(free[0] !== f0);
			bus_seen |= bus;
			ht_all &= h_t;
			hc_any |= h_c;
			misc |= ref_o | usb;
			// external source shows in phase with the internal 66, internal one inverted
			ep += int'(ebuf[0] === i66);
			fx |= {agp, dot, ext_out};
		end
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		cyc(5000);
		err_total++;
		close_out();
	end
	initial begin
		cyc(16);
		rst_n <= 1'b1;
		cyc(4);
		rd(cogc_pkg::ADDR_CFG0, 8'h1a);
		rd(cogc_pkg::ADDR_CFG3, 8'h00);
		rd(cogc_pkg::ADDR_STOP_CTL, 8'h01);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		wr(cogc_pkg::ADDR_CFG0, 8'hff);
		rd(cogc_pkg::ADDR_CFG0, 8'hfa);
		watch();
		chk(8'(vc < 11 && vc > 4), 8'h01);
		chk(8'(misc), 8'h01);
		chk(8'(ep), 8'h00);
		chk({5'h00, fx}, 8'h07);
		wr(cogc_pkg::ADDR_CFG0, 8'h40);
		watch();
		chk(8'(vc > 12), 8'h01);
		note("register");
		wr(cogc_pkg::ADDR_CFG3, 8'h38);
		rd(cogc_pkg::ADDR_CFG3, 8'h38);
		wr(cogc_pkg::ADDR_STOP_CTL, 8'h00);
		rd(cogc_pkg::ADDR_CFG0, 8'h52);
		watch();
		chk({1'b0, bus_seen}, 8'h00);
		wr(cogc_pkg::ADDR_STOP_CTL, 8'h01);
		bstop_n <= 1'b0;
		watch();
		chk({1'b0, bus_seen}, 8'h00);
		chk(8'(fc > 4), 8'h01);
		wr(cogc_pkg::ADDR_CFG3, 8'h00);
		watch();
		chk(8'(fc), 8'h00);
		bstop_n <= 1'b1;
		watch();
		chk({1'b0, bus_seen}, 8'h7f);
		wr(cogc_pkg::ADDR_CFG3, 8'h38);
		note("bus stop");
		hstop_n <= 1'b0;
		watch();
		chk({2'b00, ht_all, hc_any}, 8'h38);
		rd(cogc_pkg::ADDR_CFG0, 8'h4a);
		hstop_n <= 1'b1;
		note("host stop");
		tri_sel <= 2'b11;
		cyc(10);
		chk(8'(ext_oe), 8'h00);
		rd(cogc_pkg::ADDR_STATUS, 8'h1c);
		watch();
		chk(8'(vc > 12), 8'h01);
		chk(8'(ep), 8'h10);
		tri_sel <= 2'b01;
		cyc(10);
		rd(cogc_pkg::ADDR_STATUS, 8'h04);
		chk(8'(ext_oe), 8'h01);
		tri_sel <= 2'b00;
		note("shared pin");
		qual_n <= 1'b0;
		cyc(6);
		fsel <= 2'b01;
		mult <= 1'b1;
		cyc(8);
		chk({5'h00, strap.fsel_low, strap.mult}, 8'h04);
		qual_n <= 1'b1;
		cyc(8);
		chk({5'h00, strap.fsel_low, strap.mult}, 8'h03);
		chk(8'(hmult), 8'h01);
		note("latch");
		sdrv <= 1'b1;
		cyc(4);
		chk({6'h00, sdl_oe, sdl_in}, 8'h02);
		sdrv <= 1'b0;
		pd_n <= 1'b0;
		watch();
		chk({misc, bus_seen}, 8'h00);
		chk(8'(h_oe), 8'h00);
		chk({5'h00, fx}, 8'h00);
		rd(cogc_pkg::ADDR_STATUS, 8'h03);
		rd(cogc_pkg::ADDR_CFG3, 8'h38);
		wr(cogc_pkg::ADDR_CFG0, 8'h00);
		cyc(2);
		chk({1'b0, h_oe, h_t, h_c}, 8'h78);
		pd_n <= 1'b1;
		watch();
		chk({misc, bus_seen}, 8'hff);
		chk({5'h00, fx}, 8'h07);
		note("powerdown");
		close_out();
	end
endmodule
